// File: sldw_driver.sv
`timescale 1ns/1ps
module sldw_driver #(
  parameter int unsigned CHANNELS = sldw_pkg::CHANNELS,
  parameter int unsigned WATCHDOG_CYC = sldw_pkg::WATCHDOG_PERIOD_CYC,
  parameter int unsigned FIFO_DEPTH = sldw_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial interface pins
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_latch_load_strobe,
  input wire logic i_out_gate_n,
  output logic o_ser_data,
  // Open-circuit fault sense, one per channel
  input wire logic [CHANNELS-1:0] i_open_fault,
  // Sink outputs: drive low when enable is high
  output logic [CHANNELS-1:0] o_led_sink_outputs,
  output logic [CHANNELS-1:0] o_led_sink_outputs_oe,
  // Latched word stream for observation
  output logic o_word_valid,
  output logic [CHANNELS-1:0] o_word_data,
  input wire logic i_word_ready
);
  sldw_pkg::sldw_pins_t meta_q, sync_q, prev_q;
  logic [CHANNELS-1:0] fault_m_q, fault_s_q;
  logic [CHANNELS-1:0] shift_q, shift_d;
  logic [CHANNELS-1:0] latch_q, latch_d;
  logic ser_out_q, ser_out_d;
  logic [31:0] wd_q, wd_d;
  logic [CHANNELS-1:0] sink_q, sink_d, sink_oe_q, sink_oe_d;
  logic clk_rise, load_rise, load_fall, activity, wd_expire, wd_clear;
  logic fifo_ready, fifo_push;
  logic fifo_valid;
  logic [CHANNELS-1:0] fifo_data;

  ////////////////////////////////////////////////////////////////
  // Edge helpers, shared by the synchronised serial clock and load strobe pins
  function automatic logic rise_of(input logic now_lvl, input logic old_lvl);
    return now_lvl && !old_lvl;
  endfunction : rise_of

  function automatic logic fall_of(input logic now_lvl, input logic old_lvl);
    return !now_lvl && old_lvl;
  endfunction : fall_of

  function automatic logic toggle_of(input logic now_lvl, input logic old_lvl);
    return now_lvl ^ old_lvl;
  endfunction : toggle_of

  ////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; only the second stage is looked at
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      meta_q <= '{ser_clk: 1'b0, ser_data: 1'b0, load: 1'b0, gate_n: 1'b1};
      sync_q <= '{ser_clk: 1'b0, ser_data: 1'b0, load: 1'b0, gate_n: 1'b1};
      prev_q <= '{ser_clk: 1'b0, ser_data: 1'b0, load: 1'b0, gate_n: 1'b1};
      fault_m_q <= '0;
      fault_s_q <= '0;
    end
    else
    begin
      meta_q <= '{ser_clk: i_ser_clk, ser_data: i_ser_data,
                  load: i_latch_load_strobe, gate_n: i_out_gate_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
      fault_m_q <= i_open_fault;
      fault_s_q <= fault_m_q;
    end
  end

  // Edge detection on synchronised levels
  assign clk_rise = rise_of(sync_q.ser_clk, prev_q.ser_clk);
  assign load_rise = rise_of(sync_q.load, prev_q.load);
  assign load_fall = fall_of(sync_q.load, prev_q.load);
  // Any clock or strobe transition counts as activity
  assign activity = toggle_of(sync_q.ser_clk, prev_q.ser_clk)
    || toggle_of(sync_q.load, prev_q.load); // [R15]
  assign wd_expire = (wd_q == WATCHDOG_CYC - 1);

  ////////////////////////////////////////////////////////////////
  // Watchdog next state; the count parks at the top once expired
  always_comb
  begin
    wd_d = wd_q;
    wd_clear = 1'b0;
    if (activity)
    begin
      wd_d = '0; // [R15]
    end
    else if (wd_expire)
    begin
      // Parked count keeps the latch cleared until new activity
      wd_clear = 1'b1; // [R8]
    end
    else
    begin
      wd_d = wd_q + 32'h00000001;
    end
  end

  // Watchdog register
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wd_q <= '0;
    end
    else
    begin
      wd_q <= wd_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shift register and serial out next state
  always_comb
  begin
    shift_d = shift_q;
    ser_out_d = ser_out_q;
    if (clk_rise)
    begin
      // Data sampled with its clock edge; MSB leaves first, 16 edges later
      shift_d = {shift_q[CHANNELS-2:0], sync_q.ser_data}; // [R1] [R11]
      ser_out_d = shift_q[CHANNELS-1]; // [R2] [R14] [R7]
    end
    if (load_rise)
    begin
      // Fault capture overrides a coinciding shift edge
      shift_d = fault_s_q; // [R6] [R7]
    end
  end

  // Shift register and serial out registers; the watchdog never reaches them
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      shift_q <= sldw_pkg::SHIFT_RESET;
      ser_out_q <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d; // [R9]
      ser_out_q <= ser_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output latch next state
  always_comb
  begin
    latch_d = latch_q;
    if (wd_clear)
    begin
      // Clears latch only; shift register untouched
      latch_d = sldw_pkg::LATCH_RESET; // [R8] [R9] [R10]
    end
    else if (load_rise)
    begin
      // Data word taken before the fault word replaces it; shifts while strobe stays high can carry fault bits into the latch
      latch_d = shift_q; // [R3] [R12]
    end
    else if (sync_q.load && clk_rise)
    begin
      // Transparent to new shifts while strobe high; held once it falls
      latch_d = shift_d; // [R12] [R10]
    end
  end

  // Output latch register
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      latch_q <= sldw_pkg::LATCH_RESET;
    end
    else
    begin
      latch_q <= latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sink drive: one turns the sink on, gate high releases all
  always_comb
  begin
    sink_d = '0;
    sink_oe_d = sync_q.gate_n ? '0 : latch_q; // [R4] [R5] [R13] [R16]
  end

  // Sink registers; gate path is three clocks from pin to enable
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      sink_q <= '0;
      sink_oe_q <= '0;
    end
    else
    begin
      sink_q <= sink_d;
      sink_oe_q <= sink_oe_d;
    end
  end

  // Latched words on strobe fall go to the observation FIFO; dropped if full
  assign fifo_push = load_fall && fifo_ready;

  sldw_fifo #(
    .WIDTH(CHANNELS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(fifo_push),
    .i_in_data(latch_q),
    .o_in_ready(fifo_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(i_word_ready)
  );

  assign o_ser_data = ser_out_q;
  assign o_led_sink_outputs = sink_q;
  assign o_led_sink_outputs_oe = sink_oe_q;
  assign o_word_valid = fifo_valid;
  assign o_word_data = fifo_data;
endmodule : sldw_driver

// File: sldw_pkg.sv
// Operation
// [R1] Shift serial bits into 16-bit register
// [R2] Serial output delays input 16 clocks
// [R3] Load strobe copies shift register to latch
// [R4] Latch bits set each sink output
// [R5] Output gate switches all sinks together
// [R6] Strobe rise loads fault status into shifter
// [R7] Fault status shifts out with next data
// [R8] Inactivity timeout clears all latch bits
// [R9] Watchdog expiry leaves shift register intact
// [R10] Outputs stay off until new load
// [R11] Sample serial input on clock rise
// [R12] Latch transparent high, holds on fall
// [R13] Gate high releases all sink outputs
// [R14] Serial output updates on clock rise
// [R15] Clock or strobe edges restart watchdog
// [R16] Latch one enables sink, zero disables
package sldw_pkg;
  localparam int unsigned CHANNELS = 16;
  localparam int unsigned CLK_HZ = 50_000_000;
  // Watchdog nominal period in milliseconds
  localparam int unsigned WATCHDOG_PERIOD_MS = 1000;
  localparam int unsigned WATCHDOG_PERIOD_CYC = CLK_HZ / 1000 * WATCHDOG_PERIOD_MS;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [CHANNELS-1:0] LATCH_RESET = 16'h0000;
  localparam logic [CHANNELS-1:0] SHIFT_RESET = 16'h0000;

  // Synchronised pin levels from the host side
  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic load;
    logic gate_n;
  } sldw_pins_t;
endpackage : sldw_pkg

// File: sldw_fifo.sv
`timescale 1ns/1ps
module sldw_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic ov_q, ov_d;
  logic push, pop;
  logic [AW:0] used;

  ////////////////////////////////////////////////////////////////
  // Pointer and output register next state; output stage is registered
  always_comb
  begin
    pop = ov_q && i_out_ready;
    push = i_in_valid && (used != (AW+1)'(DEPTH));
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    out_d = out_q;
    ov_d = ov_q;
    if (pop)
    begin
      ov_d = 1'b0;
    end
    if ((!ov_q || pop) && cnt_q != '0)
    begin
      out_d = mem_q[rd_q];
      ov_d = 1'b1;
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      cnt_d = cnt_d - (AW+1)'(1);
    end
    if (push)
    begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      cnt_d = cnt_d + (AW+1)'(1);
    end
  end

  // Registers; storage has no reset to keep it small
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      ov_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      ov_q <= ov_d;
      if (push)
      begin
        mem_q[wr_q] <= i_in_data;
      end
    end
  end

  // Output stage counts as a slot, so DEPTH words fit in all
  assign used = cnt_q + (AW+1)'(ov_q);
  assign o_in_ready = (used != (AW+1)'(DEPTH));
  assign o_out_valid = ov_q;
  assign o_out_data = out_q;
endmodule : sldw_fifo

// File: sldw_props.sv
`timescale 1ns/1ps
module sldw_props #(
  parameter int unsigned WATCHDOG_CYC = 200
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Host pins
  input wire logic i_ser_clk,
  input wire logic i_latch_load_strobe,
  input wire logic i_out_gate_n,
  input wire logic o_ser_data,
  // Sinks and word stream
  input wire logic [15:0] o_led_sink_outputs,
  input wire logic [15:0] o_led_sink_outputs_oe,
  input wire logic o_word_valid,
  input wire logic [15:0] o_word_data,
  input wire logic i_word_ready
);
  // Idle cycles since the last pin edge; margin covers the sync lag
  logic [31:0] idle_q;
  logic [31:0] idle_d;
  logic [1:0] pins_q;
  always_comb
  begin
    idle_d = (pins_q != {i_ser_clk, i_latch_load_strobe}) ? 32'h0 : idle_q + 32'h1;
  end
  always_ff @(posedge i_clk)
  begin
    idle_q <= i_reset_n ? idle_d : 32'h0;
    pins_q <= {i_ser_clk, i_latch_load_strobe};
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_reset_quiet: assert property (
    $rose(i_reset_n) |-> !o_word_valid && o_led_sink_outputs_oe == 16'h0000)
    else $error("outputs active after reset");
  chk_sink_low: assert property (
    o_led_sink_outputs == 16'h0000) else $error("sink drive value not low");
  chk_gate_release: assert property (
    i_out_gate_n [*5] |-> o_led_sink_outputs_oe == 16'h0000)
    else $error("sinks enabled while gate high");
  chk_sout_cause: assert property (
    $changed(o_ser_data) |-> $past(i_ser_clk, 2)) else $error("serial out moved without clock");
  chk_wdog_clear: assert property (
    idle_q > WATCHDOG_CYC + 8 |-> o_led_sink_outputs_oe == 16'h0000)
    else $error("sinks still on after idle timeout");
  chk_latch_hold: assert property (
    (!i_latch_load_strobe && !i_out_gate_n) [*6] |->
    $stable(o_led_sink_outputs_oe) || o_led_sink_outputs_oe == 16'h0000)
    else $error("sinks changed while latch held");
  chk_word_hold: assert property (
    o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word_data))
    else $error("stalled word not held");
  chk_word_push: assert property (
    $fell(i_latch_load_strobe) && !o_word_valid |-> ##[1:6] o_word_valid)
    else $error("no word after strobe fall");
  cov_stall: cover property (o_word_valid && !i_word_ready);
  cov_wdog: cover property (idle_q == WATCHDOG_CYC + 8);
  cov_gate: cover property (i_out_gate_n [*5]);
endmodule : sldw_props
bind sldw_driver sldw_props #(.WATCHDOG_CYC(WATCHDOG_CYC)) u_props (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_ser_clk(i_ser_clk), .i_latch_load_strobe(i_latch_load_strobe),
  .i_out_gate_n(i_out_gate_n), .o_ser_data(o_ser_data), .o_led_sink_outputs(o_led_sink_outputs),
  .o_led_sink_outputs_oe(o_led_sink_outputs_oe), .o_word_valid(o_word_valid),
  .o_word_data(o_word_data), .i_word_ready(i_word_ready));

// File: sldw_host.sv
`timescale 1ns/1ps
module sldw_host (
  // Clock
  input wire logic i_clk,
  // Pins toward the driver
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_strobe
);
  // Serial clock idles low between frames
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_strobe = 1'b0;
  end
  // One bit per 160 ns period, data steady around the rise
  task automatic shift_bit(input logic b);
    o_ser_data <= b;
    repeat (4) @(posedge i_clk);
    o_ser_clk <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_ser_clk <= 1'b0;
    o_ser_data <= ~b; // Stale level never looks valid
  endtask : shift_bit
  // Strobe held long enough for the synchroniser
  task automatic load();
    o_strobe <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_strobe <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : load
endmodule : sldw_host

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_out_gate_n = 1'b0;
  logic i_word_ready = 1'b0;
  logic [15:0] i_open_fault = 16'h0000;
  logic ser_clk, ser_din, strobe, ser_out, word_valid;
  logic [15:0] sink_oe, word;
  logic [15:0] sr_m = 16'h0000;
  logic [15:0] latch_m = 16'h0000;
  logic [15:0] fifo_m[$];
  int n_errors = 0;
  int n_checks = 0;
  always #10 i_clk = ~i_clk;
  sldw_host host (.i_clk(i_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_din), .o_strobe(strobe));
  sldw_driver #(.WATCHDOG_CYC(200)) DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_ser_clk(ser_clk), .i_ser_data(ser_din), .i_latch_load_strobe(strobe),
    .i_out_gate_n(i_out_gate_n), .o_ser_data(ser_out), .i_open_fault(i_open_fault),
    .o_led_sink_outputs(), .o_led_sink_outputs_oe(sink_oe), .o_word_valid(word_valid),
    .o_word_data(word), .i_word_ready(i_word_ready));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // Old contents must trail the new word out by 16 rises
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      host.shift_bit(w[i]);
      #1;
      check({15'h0000, ser_out}, {15'h0000, sr_m[15]});
      sr_m = {sr_m[14:0], w[i]};
      @(posedge i_clk);
    end
  endtask : send
  // Shifted word reaches the latch, fault word lands in the shifter
  task automatic load(input logic [15:0] f);
    i_open_fault <= f;
    repeat (4) @(posedge i_clk);
    host.load();
    latch_m = sr_m;
    sr_m = f;
    if (fifo_m.size() < 8)
      fifo_m.push_back(latch_m);
    check(sink_oe, i_out_gate_n ? 16'h0000 : latch_m);
  endtask : load
  // Bounded drain; a leftover word counts as a hang
  task automatic drain();
    i_word_ready <= 1'b1;
    for (int k = 0; k < 64 && fifo_m.size() > 0; k++)
    begin
      @(posedge i_clk);
      if (word_valid === 1'b1)
        check(word, fifo_m.pop_front());
    end
    i_word_ready <= 1'b0;
    if (fifo_m.size() != 0)
    begin
      n_errors++;
      fifo_m.delete();
    end
  endtask : drain
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h38299FEB));
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    check(sink_oe, 16'h0000);
    // Nine loads into eight slots: the last one is refused
    for (int n = 0; n < 9; n++)
    begin
      send(16'($urandom));
      load(16'($urandom));
    end
    drain();
    i_out_gate_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    check(sink_oe, 16'h0000);
    i_out_gate_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    check(sink_oe, latch_m);
    repeat (220) @(posedge i_clk);
    check(sink_oe, 16'h0000);
    send(16'($urandom));
    check(sink_oe, 16'h0000);
    load(16'($urandom));
    drain();
    summarize();
  end
endmodule : testbench
